// File: amon_channel.sv
// Purpose: One monitor channel: select, scale, gain, offset, invert, saturate.
// Assumes: Monitored quantities come from logic on the same clock.
// Notes: Speeds in 1 rpm, torques in 0.1 percent, errors in their own units.
`timescale 1ns/100ps
`default_nettype none
module amon_channel import amon_pkg::*; (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  // Control-cycle strobe and settings.
  input wire logic i_ctrl_tick,
  input wire logic [7:0] i_select,
  input wire logic signed [15:0] i_offset,
  input wire logic signed [15:0] i_multiplier,
  // Monitored quantities.
  input wire logic signed [QTY_W-1:0] i_motor_speed,
  input wire logic signed [QTY_W-1:0] i_speed_ref,
  input wire logic signed [QTY_W-1:0] i_torque_ref,
  input wire logic signed [QTY_W-1:0] i_pos_err,
  input wire logic signed [QTY_W-1:0] i_amp_err,
  input wire logic signed [QTY_W-1:0] i_pos_ref_speed,
  input wire logic signed [QTY_W-1:0] i_load_err,
  input wire logic signed [QTY_W-1:0] i_speed_ff,
  input wire logic signed [QTY_W-1:0] i_torque_ff,
  input wire logic signed [QTY_W-1:0] i_ext_speed,
  input wire logic i_pos_ctrl,
  input wire logic i_pos_done,
  input wire logic i_ref_done,
  input wire logic i_gain2,
  // Converter code and range flag.
  output logic signed [CODE_W-1:0] o_code,
  output logic o_nonlinear
);
  logic signed [31:0] sig_mv; // Selected signal in millivolts.
  logic signed [47:0] total_mv; // Gain and offset applied.
  logic signed [47:0] out_mv; // Inverted output voltage.
  logic signed [47:0] clip_mv; // Output held to converter span.
  logic signed [63:0] code_full; // Full-width converter code from the clipped voltage, clamped at CODE_MAX.
  logic signed [CODE_W-1:0] code, next_code; // Registered code.
  logic nonlinear, next_nonlinear; // Registered range flag.

  // Pick the quantity and bring it to millivolts.
  always_comb begin
    unique case (i_select)
      SEL_MOTOR_SPEED: sig_mv = 32'(i_motor_speed);
      SEL_SPEED_REF: sig_mv = 32'(i_speed_ref);
      SEL_POS_REF_SPEED: sig_mv = 32'(i_pos_ref_speed);
      SEL_SPEED_FF: sig_mv = 32'(i_speed_ff);
      SEL_TORQUE_REF: sig_mv = 32'(i_torque_ref);
      SEL_TORQUE_FF: sig_mv = 32'(i_torque_ff);
      // Position error reads zero outside position control.
      SEL_POS_ERR: sig_mv = i_pos_ctrl ? 32'(i_pos_err) * MV_PER_POS_UNIT : '0;
      SEL_LOAD_ERR: sig_mv = 32'(i_load_err) * MV_PER_LOAD_UNIT;
      SEL_AMP_ERR: sig_mv = 32'(i_amp_err) * MV_PER_POS_UNIT;
      SEL_POS_DONE: sig_mv = i_pos_done ? MV_DONE : '0;
      SEL_REF_DONE: sig_mv = i_ref_done ? MV_DONE : '0;
      SEL_GAIN_SET: sig_mv = i_gain2 ? MV_GAIN2 : MV_GAIN1;
      SEL_EXT_SPEED: sig_mv = 32'(i_ext_speed);
      // Reserved and unknown codes drive zero volts rather than garbage.
      default: sig_mv = '0;
    endcase
  end

  // Apply gain and offset, invert, then saturate instead of wrapping.
  always_comb begin
    total_mv = (48'(sig_mv) * 48'(i_multiplier)) / MULT_UNITY
      + 48'(i_offset) * MV_PER_OFS_STEP;
    out_mv = -total_mv;
    if (out_mv > FULL_SCALE_MV) begin
      clip_mv = FULL_SCALE_MV;
    end else if (out_mv < -FULL_SCALE_MV) begin
      clip_mv = -FULL_SCALE_MV;
    end else begin
      clip_mv = out_mv;
    end
    code_full = (64'(clip_mv) * CODE_PER_MV_Q16) >>> 16;
    if (code_full > CODE_MAX) begin
      code_full = CODE_MAX;
    end
    next_code = code;
    next_nonlinear = nonlinear;
    if (i_ctrl_tick) begin
      next_code = code_full[CODE_W-1:0];
      next_nonlinear = (out_mv > LINEAR_MV) || (out_mv < -LINEAR_MV);
    end
  end

  // Hold the code between control cycles so the converter sees a stable word.
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      code <= '0;
      nonlinear <= 1'b0;
    end else begin
      code <= next_code;
      nonlinear <= next_nonlinear;
    end
  end

  assign o_code = code;
  assign o_nonlinear = nonlinear;

  code_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    !i_ctrl_tick |=> $stable(o_code))
    else $error("Code changed without a control tick.");
  done_level_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    i_ctrl_tick && i_select == SEL_POS_DONE && i_pos_done && i_multiplier == 16'sh0064
    && i_offset == 16'sh0000 |=> o_code == -16'sh4000)
    else $error("Completion did not give minus five volts.");
  gain_level_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    i_ctrl_tick && i_select == SEL_GAIN_SET && !i_gain2 && i_multiplier == 16'sh0064
    && i_offset == 16'sh0000 |=> o_code == -16'sh0CCD)
    else $error("First gain set did not give minus one volt.");
  sat_high_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    i_ctrl_tick && out_mv > FULL_SCALE_MV |=> o_code == 16'sh7FFF && o_nonlinear)
    else $error("Positive overrange did not saturate.");
  pos_err_zero_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    i_ctrl_tick && i_select == SEL_POS_ERR && !i_pos_ctrl && i_offset == 16'sh0000
    |=> o_code == 16'sh0000)
    else $error("Position error not zero outside position control.");
endmodule : amon_channel
`default_nettype wire

// File: amon_meter.sv
// Purpose: Measuring instrument model that reads both monitor outputs.
// Assumes: A code of +/-32768 stands for +/-10 V at the connector.
// Notes: Readings truncate to whole millivolts, like a coarse recorder.
`timescale 1ns/100ps
`default_nettype none
module amon_meter import amon_pkg::*; (
  // Converter codes seen at the connector.
  input wire logic signed [CODE_W-1:0] i_code1,
  input wire logic signed [CODE_W-1:0] i_code2,
  // Readings in millivolts.
  output var int o_mv1,
  output var int o_mv2
);
  // The instrument only listens, so it never loads the outputs.
  assign o_mv1 = int'(i_code1) * 10000 / 32768;
  assign o_mv2 = int'(i_code2) * 10000 / 32768;
endmodule : amon_meter
`default_nettype wire

// File: amon_pkg.sv
// Purpose: Shared constants for the two-channel analog monitor output stage.
// Assumes: APB register map with 32-bit data; output converter spans +/-10 V.
// Notes: All monitored values are converted to millivolts before gain and offset.
`default_nettype none
package amon_pkg;
  // Widths of settings, selectors, quantities and converter codes.
  localparam int SEL_W = 8;
  localparam int SET_W = 16;
  localparam int QTY_W = 24;
  localparam int CODE_W = 16;

  // Signal selection codes for each monitor channel.
  localparam logic [7:0] SEL_MOTOR_SPEED = 8'h00;
  localparam logic [7:0] SEL_SPEED_REF = 8'h01;
  localparam logic [7:0] SEL_TORQUE_REF = 8'h02;
  localparam logic [7:0] SEL_POS_ERR = 8'h03;
  localparam logic [7:0] SEL_AMP_ERR = 8'h04;
  localparam logic [7:0] SEL_POS_REF_SPEED = 8'h05;
  localparam logic [7:0] SEL_RESERVED = 8'h06;
  localparam logic [7:0] SEL_LOAD_ERR = 8'h07;
  localparam logic [7:0] SEL_POS_DONE = 8'h08;
  localparam logic [7:0] SEL_SPEED_FF = 8'h09;
  localparam logic [7:0] SEL_TORQUE_FF = 8'h0A;
  localparam logic [7:0] SEL_GAIN_SET = 8'h0B;
  localparam logic [7:0] SEL_REF_DONE = 8'h0C;
  localparam logic [7:0] SEL_EXT_SPEED = 8'h0D;

  // Reset values of the settings.
  localparam logic [7:0] MON1_SEL_RST = SEL_TORQUE_REF;
  localparam logic [7:0] MON2_SEL_RST = SEL_MOTOR_SPEED;
  localparam logic signed [15:0] OFFSET_RST = 16'sh0000;
  localparam logic signed [15:0] MULT_RST = 16'sh0064;

  // Accepted setting range, common to offsets and multipliers.
  localparam logic signed [31:0] SET_MIN = -32'sh0000_2710;
  localparam logic signed [31:0] SET_MAX = 32'sh0000_2710;

  // Scale factors in millivolts per input unit, fixed levels in millivolts, and multiplier unity.
  localparam logic signed [31:0] MV_PER_POS_UNIT = 32'sh0000_0032;
  localparam logic signed [31:0] MV_PER_LOAD_UNIT = 32'sh0000_000A;
  localparam logic signed [31:0] MV_DONE = 32'sh0000_1388;
  localparam logic signed [31:0] MV_GAIN1 = 32'sh0000_03E8;
  localparam logic signed [31:0] MV_GAIN2 = 32'sh0000_07D0;
  localparam logic signed [47:0] MV_PER_OFS_STEP = 48'sh0000_0000_0064;
  localparam logic signed [47:0] MULT_UNITY = 48'sh0000_0000_0064;

  // Output span limits in millivolts.
  localparam logic signed [47:0] LINEAR_MV = 48'sh0000_0000_1F40;
  localparam logic signed [47:0] FULL_SCALE_MV = 48'sh0000_0000_2710;

  // Millivolt to converter code factor in Q16, derived from the span.
  localparam longint CODE_SPAN = 32768;
  localparam longint CODE_PER_MV_Q16 = (CODE_SPAN * 65536) / 10000;
  localparam logic signed [63:0] CODE_MAX = 64'sh0000_0000_0000_7FFF;
  localparam logic signed [63:0] CODE_MIN = -64'sh0000_0000_0000_8000;

  // Register byte offsets on the APB port.
  localparam logic [7:0] ADDR_MON1_SEL = 8'h00;
  localparam logic [7:0] ADDR_MON2_SEL = 8'h04;
  localparam logic [7:0] ADDR_MON1_OFS = 8'h08;
  localparam logic [7:0] ADDR_MON2_OFS = 8'h0C;
  localparam logic [7:0] ADDR_MON1_MUL = 8'h10;
  localparam logic [7:0] ADDR_MON2_MUL = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_CODES = 8'h1C;
endpackage : amon_pkg
`default_nettype wire

// File: amon_setting_reg.sv
// Purpose: One signed setting register that clamps written values to range.
// Assumes: Write enable is a single-cycle pulse from the bus decoder.
// Notes: Out-of-range writes saturate to the nearest limit.
`timescale 1ns/100ps
`default_nettype none
module amon_setting_reg import amon_pkg::*; #(
  parameter logic signed [15:0] RST_VAL = 16'sh0000
) (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  // Write port.
  input wire logic i_wr_en,
  input wire logic [31:0] i_wr_data,
  // Held value.
  output logic signed [15:0] o_value
);
  logic signed [15:0] value; // Stored setting.
  logic signed [15:0] next_value; // Value after this edge.
  logic signed [31:0] wr_signed; // Written word seen as signed.

  // Clamp a write so the stored value never leaves the accepted span.
  always_comb begin
    wr_signed = $signed(i_wr_data);
    next_value = value;
    if (i_wr_en) begin
      if (wr_signed > SET_MAX) begin
        next_value = SET_MAX[15:0];
      end else if (wr_signed < SET_MIN) begin
        next_value = SET_MIN[15:0];
      end else begin
        next_value = wr_signed[15:0];
      end
    end
  end

  // Register the setting; a write is visible from the next edge on.
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      value <= RST_VAL;
    end else begin
      value <= next_value;
    end
  end

  assign o_value = value;

  set_range_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    (32'(o_value) >= SET_MIN) && (32'(o_value) <= SET_MAX))
    else $error("Setting left its accepted range.");
endmodule : amon_setting_reg
`default_nettype wire

// File: amon_top.sv
// Purpose: Two-channel analog monitor stage with an APB settings port.
// Assumes: Monitored quantities and the tick come from the control clock domain.
// Notes: Zero-wait APB slave; read data are captured in the setup cycle.
//   Settings reach the channels at once; codes change only on ticks.
//   There is no interrupt; software polls the status word.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Two channels, each with its own selector.
// - Reset selects torque on one, speed on two.
// - Speed selections scale one volt per 1000 rpm.
// - Torque selections scale one volt per 100 percent.
// - Position error 50 mV, load error 10 mV.
// - Amplifier error scales 50 mV per pulse.
// - Completion flags give five volts or zero.
// - Gain set shows one or two volts.
// - External encoder speed one volt per 1000 rpm.
// - Output is minus (signal times gain plus offset).
// - Linear only within plus or minus eight volts.
// - Each channel drives a 16-bit converter code.
// - Per-channel offset 0.1 V, multiplier 0.01 units.
// - Settings span -10000 to 10000, immediate effect.
module amon_top import amon_pkg::*; (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  // APB slave port.
  input wire logic [7:0] i_paddr,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Control-cycle strobe from the servo loop.
  input wire logic i_ctrl_tick,
  // Monitored quantities.
  input wire logic signed [QTY_W-1:0] i_motor_speed,
  input wire logic signed [QTY_W-1:0] i_speed_ref,
  input wire logic signed [QTY_W-1:0] i_torque_ref,
  input wire logic signed [QTY_W-1:0] i_pos_err,
  input wire logic signed [QTY_W-1:0] i_amp_err,
  input wire logic signed [QTY_W-1:0] i_pos_ref_speed,
  input wire logic signed [QTY_W-1:0] i_load_err,
  input wire logic signed [QTY_W-1:0] i_speed_ff,
  input wire logic signed [QTY_W-1:0] i_torque_ff,
  input wire logic signed [QTY_W-1:0] i_ext_speed,
  // Loop status flags.
  input wire logic i_pos_ctrl,
  input wire logic i_pos_done,
  input wire logic i_ref_done,
  input wire logic i_gain2,
  // Converter codes and range flags.
  output logic signed [CODE_W-1:0] o_dac1_code,
  output logic signed [CODE_W-1:0] o_dac2_code,
  output logic o_dac1_nonlinear,
  output logic o_dac2_nonlinear
);
  // Selector registers and their next values.
  logic [7:0] monitor_one_select; // Channel one choice.
  logic [7:0] next_monitor_one_select;
  logic [7:0] monitor_two_select; // Channel two choice.
  logic [7:0] next_monitor_two_select;
  // Offset and multiplier settings from the clamping registers.
  logic signed [15:0] monitor_one_offset;
  logic signed [15:0] monitor_two_offset;
  logic signed [15:0] monitor_one_multiplier;
  logic signed [15:0] monitor_two_multiplier;
  // Bus decode terms.
  logic setup_cyc; // First cycle of a transfer.
  logic wr_access; // Write takes effect at this edge.
  logic addr_ok; // Address maps to a register.
  // Registered read answer.
  logic [31:0] rdata; // Word held for the access phase.
  logic [31:0] next_rdata;
  logic slverr; // Error held for the access phase.
  logic next_slverr;
  // Write strobes for the setting registers.
  logic wr_ofs1; // Offset one.
  logic wr_ofs2; // Offset two.
  logic wr_mul1; // Multiplier one.
  logic wr_mul2; // Multiplier two.

  // Decode the APB phases; every access completes without wait states.
  always_comb begin
    setup_cyc = i_psel && !i_penable;
    wr_access = i_psel && i_penable && i_pwrite;
    // Unmapped words answer with an error.
    unique case (i_paddr)
      ADDR_MON1_SEL, ADDR_MON2_SEL, ADDR_MON1_OFS, ADDR_MON2_OFS,
      ADDR_MON1_MUL, ADDR_MON2_MUL, ADDR_STATUS, ADDR_CODES: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
    // A write lands in the access phase only.
    wr_ofs1 = wr_access && i_paddr == ADDR_MON1_OFS;
    wr_ofs2 = wr_access && i_paddr == ADDR_MON2_OFS;
    wr_mul1 = wr_access && i_paddr == ADDR_MON1_MUL;
    wr_mul2 = wr_access && i_paddr == ADDR_MON2_MUL;
  end

  // Selector writes; only the low byte is stored, the rest reads zero.
  always_comb begin
    next_monitor_one_select = monitor_one_select;
    next_monitor_two_select = monitor_two_select;
    // Channel one selector.
    if (wr_access && i_paddr == ADDR_MON1_SEL) begin
      next_monitor_one_select = i_pwdata[7:0];
    end
    // Channel two selector.
    if (wr_access && i_paddr == ADDR_MON2_SEL) begin
      next_monitor_two_select = i_pwdata[7:0];
    end
  end

  // Selectors come out of reset at their factory choices.
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      // Factory choices while reset is held.
      monitor_one_select <= MON1_SEL_RST;
      monitor_two_select <= MON2_SEL_RST;
    end else begin
      // Take the next values on every edge.
      monitor_one_select <= next_monitor_one_select;
      monitor_two_select <= next_monitor_two_select;
    end
  end

  // Read data are captured in the setup cycle so that prdata comes
  // from a flip-flop and still needs no wait state. A code that
  // changes on a tick between setup and access is seen one cycle old.
  always_comb begin
    next_rdata = rdata;
    next_slverr = slverr;
    if (setup_cyc) begin
      next_slverr = !addr_ok;
      unique case (i_paddr)
        ADDR_MON1_SEL: next_rdata = {24'h000000, monitor_one_select};
        ADDR_MON2_SEL: next_rdata = {24'h000000, monitor_two_select};
        ADDR_MON1_OFS: next_rdata = 32'(monitor_one_offset);
        ADDR_MON2_OFS: next_rdata = 32'(monitor_two_offset);
        ADDR_MON1_MUL: next_rdata = 32'(monitor_one_multiplier);
        ADDR_MON2_MUL: next_rdata = 32'(monitor_two_multiplier);
        ADDR_STATUS: next_rdata = {30'h0, o_dac2_nonlinear, o_dac1_nonlinear};
        ADDR_CODES: next_rdata = {o_dac2_code, o_dac1_code};
        // Unmapped addresses read zero alongside the error answer.
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  // Register the read answer.
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      // Nothing to answer yet.
      rdata <= 32'h00000000;
      slverr <= 1'b0;
    end else begin
      // Hold or load, as decided above.
      rdata <= next_rdata;
      slverr <= next_slverr;
    end
  end

  // Ready rises in every access phase; error only then, too.
  // Error is gated so it never shows outside an access.
  assign o_pready = i_psel && i_penable;
  assign o_pslverr = i_psel && i_penable && slverr;
  assign o_prdata = rdata;

  // Offset and multiplier registers clamp writes and take effect at once.
  amon_setting_reg #(.RST_VAL(OFFSET_RST)) u_ofs1 (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_wr_en(wr_ofs1),
    .i_wr_data(i_pwdata),
    .o_value(monitor_one_offset)
  );
  // Channel two offset.
  amon_setting_reg #(.RST_VAL(OFFSET_RST)) u_ofs2 (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_wr_en(wr_ofs2),
    .i_wr_data(i_pwdata),
    .o_value(monitor_two_offset)
  );
  // Channel one multiplier.
  amon_setting_reg #(.RST_VAL(MULT_RST)) u_mul1 (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_wr_en(wr_mul1),
    .i_wr_data(i_pwdata),
    .o_value(monitor_one_multiplier)
  );
  // Channel two multiplier.
  amon_setting_reg #(.RST_VAL(MULT_RST)) u_mul2 (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_wr_en(wr_mul2),
    .i_wr_data(i_pwdata),
    .o_value(monitor_two_multiplier)
  );

  // Channel one; a reserved selector code gives a zero signal, so only the offset shows.
  amon_channel u_ch1 (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_ctrl_tick(i_ctrl_tick),
    .i_select(monitor_one_select),
    .i_offset(monitor_one_offset),
    .i_multiplier(monitor_one_multiplier),
    .i_motor_speed(i_motor_speed),
    .i_speed_ref(i_speed_ref),
    .i_torque_ref(i_torque_ref),
    .i_pos_err(i_pos_err),
    .i_amp_err(i_amp_err),
    .i_pos_ref_speed(i_pos_ref_speed),
    .i_load_err(i_load_err),
    .i_speed_ff(i_speed_ff),
    .i_torque_ff(i_torque_ff),
    .i_ext_speed(i_ext_speed),
    .i_pos_ctrl(i_pos_ctrl),
    .i_pos_done(i_pos_done),
    .i_ref_done(i_ref_done),
    .i_gain2(i_gain2),
    .o_code(o_dac1_code),
    .o_nonlinear(o_dac1_nonlinear)
  );

  // Channel two, fully independent of channel one.
  amon_channel u_ch2 (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_ctrl_tick(i_ctrl_tick),
    .i_select(monitor_two_select),
    .i_offset(monitor_two_offset),
    .i_multiplier(monitor_two_multiplier),
    .i_motor_speed(i_motor_speed),
    .i_speed_ref(i_speed_ref),
    .i_torque_ref(i_torque_ref),
    .i_pos_err(i_pos_err),
    .i_amp_err(i_amp_err),
    .i_pos_ref_speed(i_pos_ref_speed),
    .i_load_err(i_load_err),
    .i_speed_ff(i_speed_ff),
    .i_torque_ff(i_torque_ff),
    .i_ext_speed(i_ext_speed),
    .i_pos_ctrl(i_pos_ctrl),
    .i_pos_done(i_pos_done),
    .i_ref_done(i_ref_done),
    .i_gain2(i_gain2),
    .o_code(o_dac2_code),
    .o_nonlinear(o_dac2_nonlinear)
  );

  // A write transfer: setup to a selector, then the access phase.
  sequence sel1_write_s;
    i_psel && !i_penable && i_pwrite && i_paddr == ADDR_MON1_SEL
    ##1 i_psel && i_penable;
  endsequence

  sel_write_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    sel1_write_s |=> monitor_one_select == $past(i_pwdata[7:0]))
    else $error("Selector write did not land.");
  unmapped_err_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    i_psel && !i_penable && !addr_ok ##1 i_psel && i_penable |-> o_pslverr)
    else $error("Unmapped address gave no error.");
  sel_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    !(i_psel && i_penable && i_pwrite) |=> $stable(monitor_two_select))
    else $error("Selector changed without a write.");
  range_flag_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    o_dac1_nonlinear |-> (o_dac1_code > 16'sh6666 || o_dac1_code < -16'sh6666))
    else $error("Range flag set inside the linear span.");
  range_flag2_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    o_dac2_nonlinear |-> (o_dac2_code > 16'sh6666 || o_dac2_code < -16'sh6666))
    else $error("Channel two flag set inside the linear span.");

  // In-range offset writes reach the channel with no extra delay.
  sequence ofs1_write_s;
    i_psel && !i_penable && i_pwrite && i_paddr == ADDR_MON1_OFS
    && $signed(i_pwdata) >= SET_MIN && $signed(i_pwdata) <= SET_MAX
    ##1 i_psel && i_penable;
  endsequence

  ofs_write_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    ofs1_write_s |=> monitor_one_offset == $past(i_pwdata[15:0]))
    else $error("Offset write did not land.");

  // Over-range multiplier writes stop at the upper limit, never wrap.
  sequence mul2_high_s;
    i_psel && !i_penable && i_pwrite && i_paddr == ADDR_MON2_MUL
    && $signed(i_pwdata) > SET_MAX
    ##1 i_psel && i_penable;
  endsequence

  mul_clamp_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    mul2_high_s |=> monitor_two_multiplier == SET_MAX[15:0])
    else $error("Over-range multiplier did not clamp.");
endmodule : amon_top
`default_nettype wire

// File: amon_top_test.sv
// Purpose: Self-checking bench for the two-channel analog monitor stage.
// Assumes: Zero-wait APB slave; outputs update on the edge that takes a tick.
// Notes: Expected codes are worked out here from the scaling table.
`timescale 1ns/100ps
`default_nettype none
module amon_top_test import amon_pkg::*;;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, tick = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  // Monitored quantities in the input units of the channel.
  logic signed [QTY_W-1:0] q [10] = '{1500, -2000, 700, 30, -40, 2500, 123, -300, 4000, -3500};
  logic [3:0] f = 4'h0; // Flags: gain2, ref_done, pos_done, pos_ctrl.
  logic signed [15:0] ec [2];
  logic nle [2];
  wire logic [31:0] prdata;
  wire logic pready, pslverr, nl1, nl2;
  wire logic signed [CODE_W-1:0] c1, c2;
  int mv1, mv2, n_fail = 0, checked = 0;
  int sl [2] = '{2, 0}, ml [2] = '{100, 100}, ol [2] = '{0, 0};
  always #5 clk = ~clk;
  amon_top i_dut (.i_clk_sys(clk), .i_arst_n(rst_n), .i_paddr(paddr), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_ctrl_tick(tick),
    .i_motor_speed(q[0]), .i_speed_ref(q[1]), .i_torque_ref(q[2]), .i_pos_err(q[3]),
    .i_amp_err(q[4]), .i_pos_ref_speed(q[5]), .i_load_err(q[6]), .i_speed_ff(q[7]),
    .i_torque_ff(q[8]), .i_ext_speed(q[9]), .i_pos_ctrl(f[0]), .i_pos_done(f[1]),
    .i_ref_done(f[2]), .i_gain2(f[3]), .o_dac1_code(c1), .o_dac2_code(c2),
    .o_dac1_nonlinear(nl1), .o_dac2_nonlinear(nl2));
  amon_meter i_meter (.i_code1(c1), .i_code2(c2), .o_mv1(mv1), .o_mv2(mv2));
  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  // One APB transfer; the request holds until pready is seen at an edge, or fails and ends the run after 20 edges.
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r,
                     output logic er);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (k == 20) begin
      n_fail++;
      tally_and_finish();
    end
  endtask : apb
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] r;
    logic er;
    apb(1'b1, a, d, r, er);
  endtask : wr
  // Reads one word; an error is expected only for addresses past the code word.
  task automatic rchk(string nm, logic [7:0] a, logic [31:0] e);
    logic [31:0] r;
    logic er;
    apb(1'b0, a, 32'h0, r, er);
    chk(nm, e, r);
    chk("pslverr", a > 8'h1C, er);
  endtask : rchk
  // Writes an offset (k = 0) or a multiplier (k = 1); the model clamps too.
  task automatic set(int c, int k, int v);
    wr(8'(k ? 16 + 4 * c : 8 + 4 * c), v);
    v = v > 10000 ? 10000 : (v < -10000 ? -10000 : v);
    if (k) ml[c] = v;
    else ol[c] = v;
  endtask : set
  // Signal in millivolts for a selection code, before gain and offset.
  function automatic longint sig(int s);
    case (s)
      3: return f[0] ? q[3] * 50 : 0;
      4: return q[4] * 50;
      7: return q[6] * 10;
      8: return f[1] ? 5000 : 0;
      11: return f[3] ? 2000 : 1000;
      12: return f[2] ? 5000 : 0;
      13: return q[9];
      default: return q[s < 6 ? s : s - 2];
    endcase
  endfunction : sig
  // Floor division keeps negative codes from rounding toward zero.
  function automatic logic signed [15:0] ecode(longint v);
    longint p;
    p = v * 214748;
    p = (p - ((p % 65536 + 65536) % 65536)) / 65536;
    return p > 32767 ? 16'h7FFF : p[15:0];
  endfunction : ecode
  // One control tick, then both channels against the model.
  task automatic step();
    longint v;
    @(posedge clk);
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    @(negedge clk);
    for (int c = 0; c < 2; c++) begin
      v = -((sig(sl[c]) * ml[c]) / 100 + ol[c] * 100);
      v = v > 10000 ? 10000 : (v < -10000 ? -10000 : v);
      ec[c] = ecode(v);
      nle[c] = v > 8000 || v < -8000;
      chk("code", ec[c], c ? c2 : c1);
      chk("nonlinear", nle[c], c ? nl2 : nl1);
      if ((c ? mv2 : mv1) - v > 2 || v - (c ? mv2 : mv1) > 2) begin
        chk("meter", v, c ? mv2 : mv1);
      end
    end
  endtask : step
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rchk("sel1", ADDR_MON1_SEL, 32'h2);
    rchk("sel2", ADDR_MON2_SEL, 32'h0);
    rchk("ofs2", ADDR_MON2_OFS, 32'h0);
    rchk("mul1", ADDR_MON1_MUL, 32'h64);
    step();
    // Two flag sets; channel one skips codes 05 and 06, channel two skips 06 and 07.
    for (int p = 0; p < 2; p++) begin
      @(posedge clk);
      f <= p ? 4'h6 : 4'h9;
      for (int s = 0; s < 14; s++) begin
        if (s == 5 || s == 6) continue; // Codes 05 and 06 are skipped on channel one.
        sl = '{s, (s + 1) % 14};
        wr(ADDR_MON1_SEL, s);
        wr(ADDR_MON2_SEL, sl[1]);
        step();
      end
    end
    sl = '{0, 2};
    wr(ADDR_MON1_SEL, 32'h0);
    wr(ADDR_MON2_SEL, 32'h2);
    set(0, 1, -250);
    set(0, 0, 15);
    step();
    set(0, 1, 100);
    set(0, 0, -95);
    step(); // Exactly 8 V stays linear.
    set(0, 0, -96);
    step();
    rchk("status", ADDR_STATUS, {30'h0, nle[1], nle[0]});
    set(0, 0, 0);
    set(0, 1, 10000);
    set(1, 1, 20000);
    set(1, 0, -20000);
    rchk("mul2", ADDR_MON2_MUL, 32'h2710);
    rchk("ofs2", ADDR_MON2_OFS, 32'hFFFFD8F0);
    step();
    rchk("codes", ADDR_CODES, {ec[1], ec[0]});
    rchk("unmapped", 8'h20, 32'h0);
    @(posedge clk);
    q[0] <= 24'sd9;
    repeat (5) @(posedge clk);
    chk("hold", ec[0], c1);
    step();
    tally_and_finish();
  end
endmodule : amon_top_test
`default_nettype wire
